// *** rtl/ffo_pkg.sv ***
// Shared constants and types for the fall-through FIFO flag and offset block.
package ffo_pkg;
    localparam int DATA_W = 18;
    localparam int OFFSET_W = 12;
    localparam int CMP_W = 14;
    localparam logic [11:0] EMPTY_OFFSET_RESET = 12'h01F;
    localparam logic [11:0] FULL_OFFSET_RESET = 12'h01F;
    localparam logic [1:0] STAGES_SINGLE = 2'h1;
    localparam logic [1:0] STAGES_DOUBLE = 2'h2;
    localparam logic [1:0] STAGES_TRIPLE = 2'h3;
    localparam int FLAG_PIPE_MAX = 3;
    localparam int BUFFER_ENTRIES = 2;
    localparam logic [CMP_W-1:0] HALF_EXTRA_STD = 14'h0001;
    localparam logic [CMP_W-1:0] HALF_EXTRA_FALL_THROUGH_MODE = 14'h0002;
    localparam logic [CMP_W-1:0] FALL_THROUGH_MODE_EXTRA_WORD = 14'h0001;
    localparam logic [CMP_W-1:0] AE_EXTRA_FALL_THROUGH_MODE = 14'h0001;
    localparam logic RESET_FALL_THROUGH = 1'b0;
    localparam logic RESET_SYNC_PARTIAL = 1'b0;

    typedef enum logic {
        FFO_SEL_EMPTY = 1'b0,
        FFO_SEL_FULL = 1'b1
    } ffo_sel_t;
endpackage : ffo_pkg

// *** rtl/ffo_flag_pipe.sv ***
// Register chain with a selectable tap that delays a boundary flag.
`timescale 1ns/1ns
module ffo_flag_pipe #(
    parameter int STAGES = 3,
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic advance,
    input wire logic [1:0] tap,
    input wire logic d,
    output logic q
);
    logic [STAGES-1:0] pipe;
    logic [STAGES-1:0] next_pipe;

    always_comb begin
        next_pipe = pipe;
        if (clear) begin
            next_pipe = {STAGES{RESET_VAL}};
        end else if (advance) begin
            next_pipe = {pipe[STAGES-2:0], d};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pipe <= {STAGES{RESET_VAL}};
        end else begin
            pipe <= next_pipe;
        end
    end

    // A tap of zero is treated as one stage.
    assign q = (tap == 2'h0) ? pipe[0] : pipe[tap - 2'h1];
endmodule : ffo_flag_pipe

// *** rtl/ffo_two_entry_buffer.sv ***
// Small ring buffer with valid and ready on both sides.
`timescale 1ns/1ns
module ffo_two_entry_buffer #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int FILL_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
    localparam logic [FILL_W-1:0] FULL_FILL = FILL_W'(DEPTH);

    logic [WIDTH-1:0] storage [DEPTH];
    logic [PTR_W-1:0] head, tail, next_head, next_tail;
    logic [FILL_W-1:0] fill, next_fill;
    logic push, pop;

    assign inReady = (fill != FULL_FILL);
    assign outValid = (fill != '0);
    assign outData = storage[head];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_head = head;
        next_tail = tail;
        next_fill = fill;
        if (clear) begin
            next_head = '0;
            next_tail = '0;
            next_fill = '0;
        end else begin
            if (push) begin
                next_tail = (tail == LAST) ? '0 : tail + 1'b1;
            end
            if (pop) begin
                next_head = (head == LAST) ? '0 : head + 1'b1;
            end
            if (push && !pop) begin
                next_fill = fill + 1'b1;
            end else if (pop && !push) begin
                next_fill = fill - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            head <= '0;
            tail <= '0;
            fill <= '0;
        end else begin
            head <= next_head;
            tail <= next_tail;
            fill <= next_fill;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push && !clear) begin
            storage[tail] <= inData;
        end
    end
endmodule : ffo_two_entry_buffer

// *** rtl/ffo_fifo_flags.sv ***
// FIFO with standard and fall-through timing, status flags and offset registers.
`timescale 1ns/1ns
// Function
// (R1) Fall-through: words are stored on write-clock rises while write enable is low.
// (R2) Fall-through: output ready goes low once the first word is written.
// (R3) Fall-through: almost-empty rises once the count reaches empty offset plus two.
// (R4) Fall-through: half-full goes low at half the depth plus two words.
// (R5) Fall-through: almost-full goes low at depth plus one minus full offset.
// (R6) Fall-through: input ready rises, blocking writes, after depth plus one words.
// (R7) From full, the first read drops input ready; later reads release partial flags.
// (R8) Draining fall-through: almost-empty goes low at empty offset plus one words.
// (R9) After the last word, output ready rises and reads are ignored while empty.
// (R10) Load low with write enable low: first write edge stores the empty offset.
// (R11) Further load write edges alternate between full and empty offset registers.
// (R12) Raising load ends loading; the alternation pointer is kept for the next load.
// (R13) Load and read enable low: read edges give empty then full offset.
// (R14) Offset readback works in standard timing only, never in fall-through.
// (R15) Partial flag timing, synchronous or asynchronous, is fixed during master reset.
// (R16) Asynchronous almost-empty falls on read edges, rises on write edges.
// (R17) Asynchronous almost-full falls on write edges, rises on read edges.
// (R18) Synchronous almost-empty follows read edges only, almost-full write edges only.
// (R19) Buffer stages delay only the empty and full flags, never partial flags.
// (R20) Master reset samples first-load and chain-in inputs to choose mode and buffering.
// (R21) Fall-through: the first word reaches the outputs without a read enable.
// (R22) Fall-through: a read edge with enable low consumes and advances the word.
module ffo_fifo_flags #(
    parameter int DEPTH = 256
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic masterResetN,
    input wire logic firstLoadSelect,
    input wire logic readChainIn,
    input wire logic writeChainIn,
    input wire logic writeClk,
    input wire logic writeEnableN,
    input wire logic offsetLoadN,
    input wire logic [ffo_pkg::DATA_W-1:0] dataIn,
    input wire logic readClk,
    input wire logic readEnableN,
    output logic [ffo_pkg::DATA_W-1:0] dataOut,
    output logic emptyFlagN,
    output logic fullFlagN,
    output logic almostEmptyFlagN,
    output logic almostFullFlagN,
    output logic halfFullFlagN,
    output logic fallThroughMode
);
    localparam int CW = ffo_pkg::CMP_W;
    localparam int ADDR_W = $clog2(DEPTH);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_C = CW'(DEPTH / 2);
    localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(DEPTH - 1);

    // Edge detection on the two port clocks, which are sampled as plain inputs.
    logic writeClkQ, readClkQ, writeRise, readRise;
    assign writeRise = writeClk && !writeClkQ;
    assign readRise = readClk && !readClkQ;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            writeClkQ <= 1'b0;
            readClkQ <= 1'b0;
        end else begin
            writeClkQ <= writeClk;
            readClkQ <= readClk;
        end
    end

    // Configuration captured while master reset is held.
    logic syncPartial, next_syncPartial, next_fallThroughMode;
    logic [1:0] emptyStages, fullStages, next_emptyStages, next_fullStages;

    always_comb begin
        next_fallThroughMode = fallThroughMode;
        next_syncPartial = syncPartial;
        next_emptyStages = emptyStages;
        next_fullStages = fullStages;
        if (!masterResetN) begin
            next_syncPartial = firstLoadSelect; // see (R15)
            next_fallThroughMode = !readChainIn && writeChainIn; // see (R20)
            if (!readChainIn && writeChainIn) begin
                next_emptyStages = ffo_pkg::STAGES_TRIPLE;
                next_fullStages = ffo_pkg::STAGES_DOUBLE;
            end else if (readChainIn && !writeChainIn) begin
                next_emptyStages = ffo_pkg::STAGES_DOUBLE;
                next_fullStages = ffo_pkg::STAGES_DOUBLE;
            end else begin
                next_emptyStages = ffo_pkg::STAGES_SINGLE;
                next_fullStages = ffo_pkg::STAGES_SINGLE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fallThroughMode <= ffo_pkg::RESET_FALL_THROUGH;
            syncPartial <= ffo_pkg::RESET_SYNC_PARTIAL;
            emptyStages <= ffo_pkg::STAGES_SINGLE;
            fullStages <= ffo_pkg::STAGES_SINGLE;
        end else begin
            fallThroughMode <= next_fallThroughMode;
            syncPartial <= next_syncPartial;
            emptyStages <= next_emptyStages;
            fullStages <= next_fullStages;
        end
    end

    // Offset registers and their load and readback pointers.
    logic [11:0] emptyOffset, fullOffset, next_emptyOffset, next_fullOffset;
    ffo_pkg::ffo_sel_t loadSel, readSel, next_loadSel, next_readSel;
    logic offsetWrite, offsetRead;
    assign offsetWrite = writeRise && !writeEnableN && !offsetLoadN;
    assign offsetRead = readRise && !readEnableN && !offsetLoadN && !fallThroughMode; // see (R14)

    always_comb begin
        next_emptyOffset = emptyOffset;
        next_fullOffset = fullOffset;
        next_loadSel = loadSel;
        next_readSel = readSel;
        if (!masterResetN) begin
            next_emptyOffset = ffo_pkg::EMPTY_OFFSET_RESET;
            next_fullOffset = ffo_pkg::FULL_OFFSET_RESET;
            next_loadSel = ffo_pkg::FFO_SEL_EMPTY;
            next_readSel = ffo_pkg::FFO_SEL_EMPTY;
        end else begin
            if (offsetWrite) begin
                case (loadSel)
                    ffo_pkg::FFO_SEL_EMPTY: begin
                        next_emptyOffset = dataIn[11:0]; // see (R10)
                        next_loadSel = ffo_pkg::FFO_SEL_FULL; // see (R11)
                    end
                    ffo_pkg::FFO_SEL_FULL: begin
                        next_fullOffset = dataIn[11:0]; // see (R11)
                        next_loadSel = ffo_pkg::FFO_SEL_EMPTY; // see (R12)
                    end
                    default: begin
                        next_loadSel = ffo_pkg::FFO_SEL_EMPTY;
                    end
                endcase
            end
            if (offsetRead) begin
                next_readSel = (readSel == ffo_pkg::FFO_SEL_EMPTY) ?
                    ffo_pkg::FFO_SEL_FULL : ffo_pkg::FFO_SEL_EMPTY; // see (R13)
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            emptyOffset <= ffo_pkg::EMPTY_OFFSET_RESET;
            fullOffset <= ffo_pkg::FULL_OFFSET_RESET;
            loadSel <= ffo_pkg::FFO_SEL_EMPTY;
            readSel <= ffo_pkg::FFO_SEL_EMPTY;
        end else begin
            emptyOffset <= next_emptyOffset;
            fullOffset <= next_fullOffset;
            loadSel <= next_loadSel;
            readSel <= next_readSel;
        end
    end

    // Data path: memory array, two-entry buffer, output register.
    logic [ffo_pkg::DATA_W-1:0] memory [DEPTH];
    logic [ADDR_W-1:0] memWrPtr, memRdPtr, next_memWrPtr, next_memRdPtr;
    logic [CW-1:0] memCount, next_memCount, wordCount, next_wordCount;
    logic outValid, next_outValid;
    logic [ffo_pkg::DATA_W-1:0] next_dataOut;
    logic bufInReady, bufOutValid, bufPop;
    logic [ffo_pkg::DATA_W-1:0] bufOutData;
    logic emptyDelayed, fullDelayed, fullRaw, emptyRaw;
    logic writeAccept, prefetch, stdRead, consume, loadOut, readDec;
    logic [CW-1:0] limit;

    assign limit = fallThroughMode ? DEPTH_C + ffo_pkg::FALL_THROUGH_MODE_EXTRA_WORD : DEPTH_C;
    assign fullRaw = (wordCount >= limit); // see (R6)
    assign emptyRaw = fallThroughMode ? !outValid : (wordCount == '0);
    assign writeAccept = masterResetN && writeRise && !writeEnableN && offsetLoadN
        && !fullRaw; // see (R1)
    assign prefetch = masterResetN && (memCount != '0) && bufInReady;
    // Reads are honoured only while the delayed flag shows data present.
    assign stdRead = masterResetN && !fallThroughMode && readRise && !readEnableN
        && offsetLoadN && !emptyDelayed && bufOutValid; // see (R9)
    assign consume = masterResetN && fallThroughMode && readRise && !readEnableN
        && offsetLoadN && outValid && !emptyDelayed; // see (R14) (R22)
    assign loadOut = masterResetN && fallThroughMode && readRise && bufOutValid
        && (!outValid || consume); // see (R21)
    assign bufPop = stdRead || loadOut;
    assign readDec = stdRead || consume;

    always_comb begin
        next_memWrPtr = memWrPtr;
        next_memRdPtr = memRdPtr;
        next_memCount = memCount;
        next_wordCount = wordCount;
        next_outValid = outValid;
        next_dataOut = dataOut;
        if (!masterResetN) begin
            next_memWrPtr = '0;
            next_memRdPtr = '0;
            next_memCount = '0;
            next_wordCount = '0;
            next_outValid = 1'b0;
        end else begin
            if (writeAccept) begin
                next_memWrPtr = (memWrPtr == ADDR_LAST) ? '0 : memWrPtr + 1'b1;
            end
            if (prefetch) begin
                next_memRdPtr = (memRdPtr == ADDR_LAST) ? '0 : memRdPtr + 1'b1;
            end
            if (writeAccept && !prefetch) begin
                next_memCount = memCount + 1'b1;
            end else if (prefetch && !writeAccept) begin
                next_memCount = memCount - 1'b1;
            end
            if (writeAccept && !readDec) begin
                next_wordCount = wordCount + 1'b1;
            end else if (readDec && !writeAccept) begin
                next_wordCount = wordCount - 1'b1; // see (R7)
            end
            if (loadOut) begin
                next_outValid = 1'b1;
            end else if (consume) begin
                next_outValid = 1'b0;
            end
            if (offsetRead) begin
                next_dataOut = {6'h00, (readSel == ffo_pkg::FFO_SEL_EMPTY) ?
                    emptyOffset : fullOffset}; // see (R13)
            end else if (bufPop) begin
                next_dataOut = bufOutData;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            memWrPtr <= '0;
            memRdPtr <= '0;
            memCount <= '0;
            wordCount <= '0;
            outValid <= 1'b0;
            dataOut <= 18'h00000;
        end else begin
            memWrPtr <= next_memWrPtr;
            memRdPtr <= next_memRdPtr;
            memCount <= next_memCount;
            wordCount <= next_wordCount;
            outValid <= next_outValid;
            dataOut <= next_dataOut;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (writeAccept) begin
            memory[memWrPtr] <= dataIn;
        end
    end

    ffo_two_entry_buffer #(
        .WIDTH(ffo_pkg::DATA_W),
        .DEPTH(ffo_pkg::BUFFER_ENTRIES)
    ) u_buffer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clear(!masterResetN),
        .inValid(prefetch),
        .inReady(bufInReady),
        .inData(memory[memRdPtr]),
        .outValid(bufOutValid),
        .outReady(bufPop),
        .outData(bufOutData)
    );

    // Boundary flags pass through a chain of one to three stages.
    ffo_flag_pipe #(
        .STAGES(ffo_pkg::FLAG_PIPE_MAX),
        .RESET_VAL(1'b1)
    ) u_empty_pipe (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clear(!masterResetN),
        .advance(readRise),
        .tap(emptyStages), // see (R19)
        .d(emptyRaw),
        .q(emptyDelayed)
    );

    ffo_flag_pipe #(
        .STAGES(ffo_pkg::FLAG_PIPE_MAX),
        .RESET_VAL(1'b0)
    ) u_full_pipe (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clear(!masterResetN),
        .advance(writeRise),
        .tap(fullStages), // see (R19)
        .d(fullRaw),
        .q(fullDelayed)
    );

    // Flag outputs; partial flags compare the count in a wide space.
    logic aeCond, afCond, hfCond;
    logic next_emptyFlagN, next_fullFlagN, next_almostEmptyFlagN;
    logic next_almostFullFlagN, next_halfFullFlagN;
    logic [CW-1:0] emptyOffsetW, fullOffsetW;
    assign emptyOffsetW = CW'(emptyOffset);
    assign fullOffsetW = CW'(fullOffset);
    assign aeCond = fallThroughMode ? (wordCount <= emptyOffsetW + ffo_pkg::AE_EXTRA_FALL_THROUGH_MODE)
        : (wordCount <= emptyOffsetW); // see (R3) (R8)
    assign hfCond = wordCount >= HALF_C + (fallThroughMode ? ffo_pkg::HALF_EXTRA_FALL_THROUGH_MODE
        : ffo_pkg::HALF_EXTRA_STD); // see (R4)
    assign afCond = (wordCount + fullOffsetW) >= limit; // see (R5)

    always_comb begin
        next_emptyFlagN = fallThroughMode ? emptyDelayed : !emptyDelayed; // see (R2) (R9)
        next_fullFlagN = fallThroughMode ? fullDelayed : !fullDelayed; // see (R6) (R7)
        next_halfFullFlagN = !hfCond;
        next_almostEmptyFlagN = almostEmptyFlagN;
        next_almostFullFlagN = almostFullFlagN;
        if (syncPartial) begin
            if (readRise) begin
                next_almostEmptyFlagN = !aeCond; // see (R18)
            end
            if (writeRise) begin
                next_almostFullFlagN = !afCond; // see (R18)
            end
        end else begin
            if (readRise && aeCond) begin
                next_almostEmptyFlagN = 1'b0; // see (R16)
            end else if (writeRise && !aeCond) begin
                next_almostEmptyFlagN = 1'b1; // see (R16)
            end
            if (writeRise && afCond) begin
                next_almostFullFlagN = 1'b0; // see (R17)
            end else if (readRise && !afCond) begin
                next_almostFullFlagN = 1'b1; // see (R17)
            end
        end
        if (!masterResetN) begin
            next_almostEmptyFlagN = 1'b0;
            next_almostFullFlagN = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            emptyFlagN <= 1'b0;
            fullFlagN <= 1'b1;
            almostEmptyFlagN <= 1'b0;
            almostFullFlagN <= 1'b1;
            halfFullFlagN <= 1'b1;
        end else begin
            emptyFlagN <= next_emptyFlagN;
            fullFlagN <= next_fullFlagN;
            almostEmptyFlagN <= next_almostEmptyFlagN;
            almostFullFlagN <= next_almostFullFlagN;
            halfFullFlagN <= next_halfFullFlagN;
        end
    end
endmodule : ffo_fifo_flags

// *** bench/ffo_fifo_flags_props.sv ***
// Port assertions for the fall-through FIFO flag block.
`timescale 1ns/1ns
module ffo_fifo_flags_props #(
    parameter int DEPTH = 256
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic masterResetN,
    input wire logic firstLoadSelect,
    input wire logic readChainIn,
    input wire logic writeChainIn,
    input wire logic writeClk,
    input wire logic readClk,
    input wire logic [ffo_pkg::DATA_W-1:0] dataOut,
    input wire logic emptyFlagN,
    input wire logic fullFlagN,
    input wire logic almostEmptyFlagN,
    input wire logic almostFullFlagN,
    input wire logic halfFullFlagN,
    input wire logic fallThroughMode
);
    logic syncCap;
    logic ftCap;
    logic [2:0] since;
    // Captured configuration and edge count since master reset.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncCap <= 1'b0;
            ftCap <= 1'b0;
            since <= 3'h0;
        end else if (!masterResetN) begin
            syncCap <= firstLoadSelect;
            ftCap <= !readChainIn && writeChainIn;
            since <= 3'h0;
        end else if (!since[2]) begin
            since <= since + 3'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n || !masterResetN);
    sequence rRise; $past(readClk) && !$past(readClk, 2); endsequence
    sequence wRise; $past(writeClk) && !$past(writeClk, 2); endsequence
    sequence rRiseLate; $past(readClk, 2) && !$past(readClk, 3); endsequence
    sequence wRiseLate; $past(writeClk, 2) && !$past(writeClk, 3); endsequence
    sequence mrHeld; !masterResetN [*4]; endsequence
    a_mode_capture: assert property (
        masterResetN && $past(masterResetN) |-> fallThroughMode == ftCap)
        else $error("Mode not as configured.");
    a_reset_flags: assert property (disable iff (!reset_n) mrHeld |->
        emptyFlagN == ftCap && fullFlagN == !ftCap && !almostEmptyFlagN && almostFullFlagN
        && halfFullFlagN) else $error("Bad flags in master reset.");
    a_empty_edge: assert property (
        since[2] && $changed(emptyFlagN) |-> rRiseLate)
        else $error("Empty flag moved off a read rise.");
    a_full_edge: assert property (
        since[2] && $changed(fullFlagN) |-> wRiseLate)
        else $error("Full flag moved off a write rise.");
    a_ae_clock: assert property (
        since[2] && $changed(almostEmptyFlagN) |->
        if (!syncCap && almostEmptyFlagN) wRise else rRise)
        else $error("Almost-empty on wrong clock.");
    a_af_clock: assert property (
        since[2] && $changed(almostFullFlagN) |->
        if (syncCap || !almostFullFlagN) wRise else rRise)
        else $error("Almost-full on wrong clock.");
    a_ft_data: assert property (
        since[2] && fallThroughMode && $changed(dataOut) |-> rRise)
        else $error("Data moved off a read rise.");
    a_half_ready: assert property (
        since[2] && fallThroughMode && !halfFullFlagN |-> !emptyFlagN)
        else $error("Half-full with no word shown.");
endmodule : ffo_fifo_flags_props

bind ffo_fifo_flags ffo_fifo_flags_props #(.DEPTH(DEPTH)) ffo_fifo_flags_props_inst (
    .sys_clk(sys_clk), .reset_n(reset_n), .masterResetN(masterResetN),
    .firstLoadSelect(firstLoadSelect), .readChainIn(readChainIn),
    .writeChainIn(writeChainIn), .writeClk(writeClk), .readClk(readClk),
    .dataOut(dataOut), .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
    .almostEmptyFlagN(almostEmptyFlagN), .almostFullFlagN(almostFullFlagN),
    .halfFullFlagN(halfFullFlagN), .fallThroughMode(fallThroughMode)
);

// *** bench/ffo_port_agent.sv ***
// Writer and reader model on two free-running port clocks.
`timescale 1ns/1ns
module ffo_port_agent (
    input wire logic sys_clk,
    output logic writeClk,
    output logic writeEnableN = 1'b1,
    output logic offsetLoadN = 1'b1,
    output logic [ffo_pkg::DATA_W-1:0] dataIn = 18'h00000,
    output logic readClk,
    output logic readEnableN = 1'b1
);
    logic [1:0] wPhase = 2'h0;
    logic [2:0] rPhase = 3'h0;
    // Port clocks run freely with periods of four and five cycles.
    always @(posedge sys_clk) begin
        wPhase <= wPhase + 2'h1;
        rPhase <= (rPhase == 3'h4) ? 3'h0 : rPhase + 3'h1;
    end
    assign writeClk = wPhase[1];
    assign readClk = rPhase > 3'h2;
    task automatic strobe(input logic wr, logic [17:0] d, logic ld, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge sys_clk);
            ok = wr ? wPhase == 2'h1 : rPhase == 3'h2;
        end
        @(posedge sys_clk);
        if (wr) writeEnableN <= 1'b0;
        else readEnableN <= 1'b0;
        offsetLoadN <= ld;
        dataIn <= d;
        @(posedge sys_clk);
        writeEnableN <= 1'b1;
        readEnableN <= 1'b1;
        offsetLoadN <= 1'b1;
        dataIn <= ~d;
    endtask : strobe
endmodule : ffo_port_agent

// *** bench/ffo_fifo_flags_bench.sv ***
// Self-checking bench for the fall-through FIFO flag block.
`timescale 1ns/1ns
module ffo_fifo_flags_bench;
    localparam int D = 16;
    localparam logic [11:0] CFGS = 12'h46C;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic masterResetN = 1'b1;
    logic [2:0] cfg = 3'h0;
    logic writeClk, writeEnableN, offsetLoadN, readClk, readEnableN, ft, ok, known;
    logic emptyFlagN, fullFlagN, almostEmptyFlagN, almostFullFlagN, halfFullFlagN;
    logic fallThroughMode;
    logic [ffo_pkg::DATA_W-1:0] dataIn, dataOut, lastOut;
    logic [ffo_pkg::DATA_W-1:0] q[$];
    logic [31:0] lfsr = 32'h2369C5F3;
    int n_mismatch = 0;
    int comparisons = 0;
    int eo, fo;
    always #25 sys_clk = ~sys_clk;
    ffo_port_agent ffo_port_agent_inst (.*);
    ffo_fifo_flags #(.DEPTH(D)) ffo_fifo_flags_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .masterResetN(masterResetN),
        .firstLoadSelect(cfg[2]), .readChainIn(cfg[1]), .writeChainIn(cfg[0]),
        .writeClk(writeClk), .writeEnableN(writeEnableN), .offsetLoadN(offsetLoadN),
        .dataIn(dataIn), .readClk(readClk), .readEnableN(readEnableN), .dataOut(dataOut),
        .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN), .almostEmptyFlagN(almostEmptyFlagN),
        .almostFullFlagN(almostFullFlagN), .halfFullFlagN(halfFullFlagN),
        .fallThroughMode(fallThroughMode)
    );
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : step
    // Expected flag pins for c stored words.
    function automatic logic [4:0] flags(input int c);
        if (ft) return {c == 0, c == D + 1, c > eo + 1, c < D + 1 - fo, c < D / 2 + 2};
        return {c != 0, c != D, c > eo, c < D - fo, c < D / 2 + 1};
    endfunction : flags
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, logic [17:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic settle();
        logic [4:0] got;
        repeat (30) @(posedge sys_clk);
        @(negedge sys_clk);
        got = {emptyFlagN, fullFlagN, almostEmptyFlagN, almostFullFlagN, halfFullFlagN};
        check("flags", 18'(flags(q.size())), 18'(got));
        if (ft ? q.size() > 0 : known) check("dataOut", ft ? q[0] : lastOut, dataOut);
    endtask : settle
    task automatic xfer(input logic wr, logic [17:0] d, logic ld);
        ffo_port_agent_inst.strobe(wr, d, ld, ok);
        if (!ok) begin
            n_mismatch++;
            tally_and_finish();
        end
        if (wr && ld && q.size() < D + int'(ft)) q.push_back(d);
        if (!wr && ld && q.size() > 0) lastOut = q.pop_front();
        known |= !wr;
        if (wr && ld) settle();
    endtask : xfer
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            cfg <= CFGS[3*i +: 3];
            @(posedge sys_clk);
            masterResetN <= 1'b0;
            repeat (4) @(posedge sys_clk);
            masterResetN <= 1'b1;
            repeat (3) @(negedge sys_clk);
            ft = !cfg[1] && cfg[0];
            q.delete();
            known = 1'b0;
            check("fallThroughMode", 18'(ft), 18'(fallThroughMode));
            lfsr = step(lfsr);
            eo = int'(lfsr[1:0]) + 1;
            fo = int'(lfsr[3:2]) + 1;
            xfer(1'b1, 18'(lfsr[31:20]), 1'b0);
            xfer(1'b1, 18'(fo), 1'b0);
            xfer(1'b1, 18'(eo), 1'b0);
            settle();
            for (int k = 0; k <= D + 1; k++) begin
                lfsr = step(lfsr);
                xfer(1'b1, lfsr[17:0], 1'b1);
            end
            xfer(1'b0, 18'h00000, 1'b0);
            lastOut = 18'(eo);
            settle();
            xfer(1'b0, 18'h00000, 1'b0);
            lastOut = 18'(fo);
            settle();
            for (int k = 0; k <= D + 1; k++) begin
                xfer(1'b0, 18'h00000, 1'b1);
                settle();
            end
            $display("Config %b done", cfg);
        end
        tally_and_finish();
    end
endmodule : ffo_fifo_flags_bench
